/* tb/pll_pd_and_exact_freq_regs_tb.sv */
// Purpose: Self-checking bench for the phase detector and exact frequency registers
// Assumes: Inputs change on the falling clock edge
// Notes:   Expected words are built here from field positions, not read from the design
`timescale 1ns/1ns
`default_nettype none
module pll_pd_and_exact_freq_regs_tb;
  logic clk = 1'b0, rst = 1'b1;                  // Clock and reset
  logic spiEnable, spiClock, spiDataIn, sdoOut, sdoOe_n;   // Serial port
  logic detUpRaw = 1'b0, detDownRaw = 1'b0, compTick = 1'b0; // Comparator side
  logic [15:0] phaseErrorPs = 16'h0000;          // Phase error in ps
  ppe_pkg::ppe_pd_ctrl_s pdCtrl;                 // Register copy
  logic [13:0] exactChannelCount;
  logic sdoHighVoltage, pumpUp, pumpDown, cycleSlipInject, exactEnable, correctionPulse;
  int fails = 0, num_checks = 0, m, d, r, cnt;
  logic [23:0] rdata, w;
  logic oe;
  int thr [4] = '{60000, 5400, 14400, 24100};    // Code 0 uses a large error

  initial forever #10 clk = ~clk;                // 50 MHz

  ppe_spi_host host (.clk(clk), .spiEnable(spiEnable), .spiClock(spiClock),
    .spiDataIn(spiDataIn), .sdoOut(sdoOut), .sdoOe_n(sdoOe_n));
  ppe_top DUT (.clk(clk), .rst(rst), .spiEnable(spiEnable), .spiClock(spiClock),
    .spiDataIn(spiDataIn), .sdoOut(sdoOut), .sdoOe_n(sdoOe_n), .detUpRaw(detUpRaw),
    .detDownRaw(detDownRaw), .phaseErrorPs(phaseErrorPs), .compTick(compTick),
    .pdCtrl(pdCtrl), .exactChannelCount(exactChannelCount),
    .sdoHighVoltage(sdoHighVoltage), .pumpUp(pumpUp), .pumpDown(pumpDown),
    .cycleSlipInject(cycleSlipInject), .exactEnable(exactEnable),
    .correctionPulse(correctionPulse));

  // Compare and count
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    num_checks++;
    if (seen !== exp) begin
      $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
      fails++;
    end
  endtask

  task automatic wr(input logic [5:0] addr, input logic [23:0] data);
    host.frame(1'b0, addr, data, 31, rdata, oe);
  endtask

  // Read back; the enable must be low through the whole data phase
  task automatic rdchk(input logic [5:0] addr, input logic [23:0] exp);
    host.frame(1'b1, addr, 24'h5a5a5a, 31, rdata, oe);
    check(rdata, exp);
    check(oe, 1'b1);
    check(sdoOe_n, 1'b1);
  endtask

  task automatic print_verdict;
    if (fails == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Hang guard
  initial begin
    #1000000;
    fails++;
    print_verdict();
  end

  initial begin
    repeat (5) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    check(pdCtrl, 24'h0f8061);
    check(exactEnable, 1'b0);
    check(exactChannelCount, 14'h0000);
    rdchk(ppe_pkg::ADDR_PD_CTRL, 24'h0f8061);
    rdchk(ppe_pkg::ADDR_EXACT, 24'h000000);
    // Enables gate raw levels, force bits override them
    for (m = 0; m < 3; m++) begin
      w = (m == 0) ? 24'h0f8061 : (m == 1) ? 24'h0f8001 : 24'h0f8601;
      wr(ppe_pkg::ADDR_PD_CTRL, w);
      for (r = 0; r < 4; r++) begin
        detUpRaw   = r[0];
        detDownRaw = r[1];
        repeat (2) @(negedge clk);
        check({pumpUp, pumpDown}, {(r[0] & w[5]) | w[9], (r[1] & w[6]) | w[10]});
      end
    end
    // Each guard code at its threshold and one picosecond past it
    for (m = 0; m < 4; m++) begin
      wr(ppe_pkg::ADDR_PD_CTRL, 24'h0f8061 | (24'(m) << 7));
      for (d = 0; d < 2; d++) begin
        phaseErrorPs = 16'(thr[m] + d);
        repeat (2) @(negedge clk);
        check(cycleSlipInject, (m != 0) && (d == 1));
      end
    end
    wr(ppe_pkg::ADDR_PD_CTRL, 24'h4f8061);
    check(sdoHighVoltage, 1'b1);
    wr(ppe_pkg::ADDR_PD_CTRL, 24'hbff819);
    check(pdCtrl, 24'hbff819);
    check(sdoHighVoltage, 1'b0);
    // Truncated frame must be dropped
    host.frame(1'b0, ppe_pkg::ADDR_PD_CTRL, 24'h000000, 20, rdata, oe);
    rdchk(ppe_pkg::ADDR_PD_CTRL, 24'hbff819);
    rdchk(6'h3f, 24'h000000);
    // Exact mode: one correction every three comparison ticks
    wr(ppe_pkg::ADDR_EXACT, 24'h000003);
    check(exactEnable, 1'b1);
    cnt = 0;
    for (r = 0; r < 21; r++) begin
      compTick = (r < 18) && (r % 2 == 0);
      @(negedge clk);
      cnt += int'(correctionPulse === 1'b1);
    end
    check(cnt, 3);
    wr(ppe_pkg::ADDR_EXACT, 24'h000001);
    check(exactEnable, 1'b0);
    wr(ppe_pkg::ADDR_EXACT, 24'h003fff);
    rdchk(ppe_pkg::ADDR_EXACT, 24'h003fff);
    check(exactChannelCount, 14'h3fff);
    // Mid-run reset puts both registers back to their defaults
    rst = 1'b1;
    repeat (5) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    check(pdCtrl, 24'h0f8061);
    check({exactEnable, exactChannelCount}, 15'h0000);
    rdchk(ppe_pkg::ADDR_EXACT, 24'h000000);
    print_verdict();
  end
endmodule // pll_pd_and_exact_freq_regs_tb
`default_nettype wire

/* tb/ppe_spi_host.sv */
// Purpose: Behavioural serial host that writes and reads the configuration registers
// Assumes: Three clk per serial clock level, clear of the two-clk minimum
// Notes:   Data is presented while the serial clock is low; reads sample just before a rise
`timescale 1ns/1ns
`default_nettype none
module ppe_spi_host (
  // Clock
  input  wire logic clk,
  // Serial port
  output logic      spiEnable,
  output logic      spiClock,
  output logic      spiDataIn,
  input  wire logic sdoOut,
  input  wire logic sdoOe_n
);
  // Pins idle low from time zero
  initial begin
    spiEnable = 1'b0;
    spiClock  = 1'b0;
    spiDataIn = 1'b0;
  end

  // One frame: rw flag, address, data; nBits below 31 makes a truncated frame
  task automatic frame(input logic rd, input logic [5:0] addr, input logic [23:0] data,
                       input int nBits, output logic [23:0] rdata, output logic oeLow);
    logic [30:0] word;
    int          i;
    word  = {rd, addr, data};
    rdata = 24'h000000;
    oeLow = 1'b1;
    @(negedge clk);
    spiEnable = 1'b1;
    for (i = 0; i < nBits; i++) begin
      spiDataIn = word[30-i];
      repeat (3) @(negedge clk);
      // Read data is sampled while settled, one level after the fall
      if (rd && i >= 7) begin
        rdata = {rdata[22:0], sdoOut};
        oeLow = oeLow & (sdoOe_n === 1'b0);
      end
      spiClock = 1'b1;
      repeat (3) @(negedge clk);
      spiClock = 1'b0;
    end
    // Released data line shows the inverse so a stale bit cannot pass
    spiDataIn = ~spiDataIn;
    repeat (2) @(negedge clk);
    spiEnable = 1'b0;
    // Gap covers the two-cycle commit and the output copy
    repeat (4) @(negedge clk);
  endtask
endmodule // ppe_spi_host
`default_nettype wire

/* verilog/ppe_cfg_reg.sv */
// Purpose: One 24-bit configuration register with a fixed power-on value
// Assumes: Write strobe is a one-cycle pulse from the serial port
// Notes:   Every bit, reserved or not, keeps what is written
`timescale 1ns/1ns
`default_nettype none
module ppe_cfg_reg #(
  parameter logic [23:0] RESET_VAL = 24'h000000
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Write side
  input  wire logic        wrEn,
  input  wire logic [23:0] wrData,
  // Stored value
  output logic      [23:0] q
);

  // Whole word written at once; reserved bits are stored as well
  always_ff @(posedge clk) begin
    if (rst) begin
      q <= RESET_VAL;
    end else if (wrEn) begin
      q <= wrData;
    end
  end

endmodule // ppe_cfg_reg
`default_nettype wire

/* verilog/ppe_exact_corr.sv */
// Purpose: Correction-rate counter for exact frequency mode
// Assumes: compTick pulses once per phase detector comparison cycle
// Notes:   A count below two leaves the mode off and the counter idle
`timescale 1ns/1ns
`default_nettype none
module ppe_exact_corr (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Configuration and timing
  input  wire logic [13:0] channelCount,
  input  wire logic        compTick,
  // Results
  output logic             exactEnable,
  output logic             correctionPulse
);

  logic [13:0] phaseCount;  // Comparison cycles since last correction

  // Mode is on only for counts of two and above
  wire modeOn = (channelCount >= ppe_pkg::EXACT_MIN_COUNT);
  // Wrap on the last cycle, or when a smaller count was just programmed
  wire atWrap = (phaseCount >= channelCount - 14'h0001);

  // Correction strobe once per channelCount comparisons keeps the grid exact
  always_ff @(posedge clk) begin
    if (rst) begin
      phaseCount      <= 14'h0000;
      exactEnable     <= 1'b0;
      correctionPulse <= 1'b0;
    end else begin
      exactEnable     <= modeOn;
      correctionPulse <= modeOn && compTick && atWrap;
      if (!modeOn) begin
        phaseCount <= 14'h0000;
      end else if (compTick) begin
        phaseCount <= atWrap ? 14'h0000 : phaseCount + 14'h0001;
      end
    end
  end

endmodule // ppe_exact_corr
`default_nettype wire

/* verilog/ppe_pkg.sv */
// Purpose: Shared constants and types for the phase detector and exact frequency registers
// Assumes: 24-bit registers reached through a 4-wire serial port sampled on clk
// Notes:   Field layout of the phase detector register is carried by ppe_pd_ctrl_s
package ppe_pkg;

  // Register addresses on the serial port
  localparam logic [5:0] ADDR_PD_CTRL = 6'h0b;  // Phase detector control
  localparam logic [5:0] ADDR_EXACT   = 6'h0c;  // Exact frequency channel count

  // Register width and serial frame shape
  localparam int         REG_W      = 24;
  localparam int         ADDR_W     = 6;
  localparam logic [4:0] HEAD_LAST  = 5'h06;  // Index of last header bit (rw + 6 address bits)
  localparam logic [4:0] FRAME_LAST = 5'h1e;  // Index of last data bit in a 31-bit frame
  localparam int         MSB        = 23;     // Bit shifted out first

  // Phase detector field defaults
  localparam logic [2:0]  PD_DEL_RESET   = 3'h1;   // Recommended reset path delay
  localparam logic [10:0] PD_RSVD_RESET  = 11'h1f0;
  localparam logic        PD_UP_RESET    = 1'h1;
  localparam logic        PD_DN_RESET    = 1'h1;

  // Exact frequency field layout and limits
  localparam int          EXACT_CNT_W     = 14;
  localparam logic [13:0] EXACT_MIN_COUNT = 14'h0002;  // 0 and 1 mean disabled
  localparam logic [23:0] EXACT_RESET     = 24'h000000;

  // Cycle slip guard codes and thresholds, in picoseconds
  localparam logic [1:0]  GUARD_OFF     = 2'h0;
  localparam logic [1:0]  GUARD_LVL1    = 2'h1;
  localparam logic [1:0]  GUARD_LVL2    = 2'h2;
  localparam logic [1:0]  GUARD_LVL3    = 2'h3;
  localparam logic [15:0] GUARD_THR1_PS = 16'h1518;  // 5.4 ns
  localparam logic [15:0] GUARD_THR2_PS = 16'h3840;  // 14.4 ns
  localparam logic [15:0] GUARD_THR3_PS = 16'h5e24;  // 24.1 ns

  // Phase detector control register, bit 23 down to bit 0
  typedef struct packed {
    logic        rsvdTop;              // Bit 23
    logic        sdoHighVoltage;       // Bit 22: 0 = 1.8 V, 1 = 3.3 V drive
    logic [10:0] rsvdMid;              // Bits 21:11
    logic        forcePumpDown;        // Bit 10
    logic        forcePumpUp;          // Bit 9
    logic [1:0]  cycleSlipGuardMode;   // Bits 8:7
    logic        detectorDownEnable;   // Bit 6
    logic        detectorUpEnable;     // Bit 5
    logic [1:0]  rsvdLow;              // Bits 4:3
    logic [2:0]  detectorResetDelay;   // Bits 2:0
  } ppe_pd_ctrl_s;

  localparam ppe_pd_ctrl_s PD_RESET = '{
    rsvdTop: 1'h0, sdoHighVoltage: 1'h0, rsvdMid: PD_RSVD_RESET,
    forcePumpDown: 1'h0, forcePumpUp: 1'h0, cycleSlipGuardMode: GUARD_OFF,
    detectorDownEnable: PD_DN_RESET, detectorUpEnable: PD_UP_RESET,
    rsvdLow: 2'h0, detectorResetDelay: PD_DEL_RESET};

  // Serial port states, one-hot
  typedef enum logic [3:0] {
    SP_IDLE  = 4'b0001,
    SP_HEAD  = 4'b0010,
    SP_WRITE = 4'b0100,
    SP_READ  = 4'b1000
  } ppe_spi_e;

endpackage

/* verilog/ppe_top.sv */
// Purpose: Phase detector control and exact frequency registers behind a serial port
// Assumes: Serial pins are synchronous to clk and change slowly against it
// Notes:   Frame is rw bit, 6 address bits, 24 data bits, most significant first
`timescale 1ns/1ns
`default_nettype none
module ppe_top (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst,
  // Serial port
  input  wire logic                  spiEnable,
  input  wire logic                  spiClock,
  input  wire logic                  spiDataIn,
  output logic                       sdoOut,
  output logic                       sdoOe_n,
  // Phase comparator side
  input  wire logic                  detUpRaw,
  input  wire logic                  detDownRaw,
  input  wire logic [15:0]           phaseErrorPs,
  input  wire logic                  compTick,
  // Configuration outputs
  output var ppe_pkg::ppe_pd_ctrl_s  pdCtrl,
  output logic [13:0]                exactChannelCount,
  output logic                       sdoHighVoltage,
  // Loop control outputs
  output logic                       pumpUp,
  output logic                       pumpDown,
  output logic                       cycleSlipInject,
  output logic                       exactEnable,
  output logic                       correctionPulse
);

  // Serial port state
  ppe_pkg::ppe_spi_e  spiState;      // Frame phase
  logic               sckPrev;       // Last sampled serial clock
  logic [4:0]         bitCount;      // Bits taken in this frame
  logic [23:0]        shiftIn;       // Incoming header and data
  logic [23:0]        shiftOut;      // Outgoing read data
  logic [5:0]         frameAddr;     // Address held from the header
  logic               wrStrobe;      // One-cycle commit of a full write
  logic [23:0]        wrWord;        // Data for that commit
  logic [23:0]        pdWord;        // Phase detector register
  logic [23:0]        exactWord;     // Exact frequency register

  // Edge detection; pins count as synchronous, so no synchroniser
  wire sckRise = spiClock && !sckPrev;
  wire sckFall = !spiClock && sckPrev;
  // A finished frame ignores further clocks until the enable drops
  wire frameDone = (spiState == ppe_pkg::SP_IDLE) && (bitCount != 5'h00);

  // Header decode: bit 6 of the header is the read flag
  wire [6:0] headNow  = {shiftIn[5:0], spiDataIn};
  wire       headRead = headNow[6];
  wire [5:0] headAddr = headNow[5:0];

  // Register decode for writes
  wire selPd    = (frameAddr == ppe_pkg::ADDR_PD_CTRL);
  wire selExact = (frameAddr == ppe_pkg::ADDR_EXACT);
  wire wrPd     = wrStrobe && selPd;
  wire wrExact  = wrStrobe && selExact;

  // Read mux; unmapped addresses read as zero
  wire [23:0] readWord = (headAddr == ppe_pkg::ADDR_PD_CTRL) ? pdWord :
                         (headAddr == ppe_pkg::ADDR_EXACT)   ? exactWord :
                         24'h000000;

  // Field view of the phase detector register
  ppe_pkg::ppe_pd_ctrl_s pdFields;
  assign pdFields = ppe_pkg::ppe_pd_ctrl_s'(pdWord);

  // Cycle slip threshold chosen by mode code; code three takes the widest window
  wire [1:0]  guardMode      = pdFields.cycleSlipGuardMode;
  wire [15:0] guardThreshold = (guardMode == ppe_pkg::GUARD_LVL1) ? ppe_pkg::GUARD_THR1_PS :
                               (guardMode == ppe_pkg::GUARD_LVL2) ? ppe_pkg::GUARD_THR2_PS :
                               ppe_pkg::GUARD_THR3_PS;
  wire        guardOn        = (guardMode != ppe_pkg::GUARD_OFF);

  // Pump drive: enable gates the detector, force overrides both
  wire next_pumpUp      = (detUpRaw && pdFields.detectorUpEnable) || pdFields.forcePumpUp;
  wire next_pumpDown    = (detDownRaw && pdFields.detectorDownEnable) || pdFields.forcePumpDown;
  wire next_slipInject  = guardOn && (phaseErrorPs > guardThreshold);

  // Serial clock history
  always_ff @(posedge clk) begin
    if (rst) begin
      sckPrev <= 1'b0;
    end else begin
      sckPrev <= spiClock;
    end
  end

  // Frame state machine; dropping the enable ends any frame
  always_ff @(posedge clk) begin
    if (rst) begin
      spiState  <= ppe_pkg::SP_IDLE;
      bitCount  <= 5'h00;
      frameAddr <= 6'h00;
    end else if (!spiEnable) begin
      spiState <= ppe_pkg::SP_IDLE;
      bitCount <= 5'h00;
    end else if (sckRise && !frameDone) begin
      bitCount <= bitCount + 5'h01;
      unique case (spiState)
        ppe_pkg::SP_IDLE, ppe_pkg::SP_HEAD: begin
          spiState <= ppe_pkg::SP_HEAD;
          if (bitCount == ppe_pkg::HEAD_LAST) begin
            frameAddr <= headAddr;
            spiState  <= headRead ? ppe_pkg::SP_READ : ppe_pkg::SP_WRITE;
          end
        end
        ppe_pkg::SP_WRITE: begin
          // Extra clocks past the frame are ignored
          if (bitCount == ppe_pkg::FRAME_LAST) begin
            spiState <= ppe_pkg::SP_IDLE;
          end
        end
        ppe_pkg::SP_READ: begin
          if (bitCount == ppe_pkg::FRAME_LAST) begin
            spiState <= ppe_pkg::SP_IDLE;
          end
        end
      endcase
    end
  end

  // Input shifter and write commit; a short write frame is dropped
  always_ff @(posedge clk) begin
    if (rst) begin
      shiftIn  <= 24'h000000;
      wrStrobe <= 1'b0;
      wrWord   <= 24'h000000;
    end else begin
      wrStrobe <= 1'b0;
      if (spiEnable && sckRise) begin
        shiftIn <= {shiftIn[22:0], spiDataIn};
        if (spiState == ppe_pkg::SP_WRITE && bitCount == ppe_pkg::FRAME_LAST) begin
          wrStrobe <= 1'b1;
          wrWord   <= {shiftIn[22:0], spiDataIn};
        end
      end
    end
  end

  // Output shifter; data leads each rising edge by half a serial clock
  always_ff @(posedge clk) begin
    if (rst) begin
      shiftOut <= 24'h000000;
      sdoOut   <= 1'b0;
      sdoOe_n  <= 1'b1;
    end else if (!spiEnable) begin
      sdoOe_n <= 1'b1;
    end else if (sckRise && spiState == ppe_pkg::SP_HEAD && bitCount == ppe_pkg::HEAD_LAST) begin
      shiftOut <= readWord;
    end else if (sckFall && spiState == ppe_pkg::SP_READ) begin
      sdoOut   <= shiftOut[ppe_pkg::MSB];
      sdoOe_n  <= 1'b0;
      shiftOut <= {shiftOut[22:0], 1'b0};
    end
  end

  // Phase detector register, reset path delay one and both outputs on
  ppe_cfg_reg #(
    .RESET_VAL (24'(ppe_pkg::PD_RESET))
  ) uPdReg (
    .clk    (clk),
    .rst    (rst),
    .wrEn   (wrPd),
    .wrData (wrWord),
    .q      (pdWord)
  );

  // Exact frequency register, cleared so the mode starts off
  ppe_cfg_reg #(
    .RESET_VAL (ppe_pkg::EXACT_RESET)
  ) uExactReg (
    .clk    (clk),
    .rst    (rst),
    .wrEn   (wrExact),
    .wrData (wrWord),
    .q      (exactWord)
  );

  // Correction rate counter; range of the count is the host's duty
  ppe_exact_corr uExactCorr (
    .clk             (clk),
    .rst             (rst),
    .channelCount    (exactWord[ppe_pkg::EXACT_CNT_W-1:0]),
    .compTick        (compTick),
    .exactEnable     (exactEnable),
    .correctionPulse (correctionPulse)
  );

  // Registered copies of configuration for the analog side
  always_ff @(posedge clk) begin
    if (rst) begin
      pdCtrl            <= ppe_pkg::PD_RESET;
      exactChannelCount <= 14'h0000;
      sdoHighVoltage    <= 1'b0;
    end else begin
      pdCtrl            <= pdFields;
      exactChannelCount <= exactWord[ppe_pkg::EXACT_CNT_W-1:0];
      sdoHighVoltage    <= pdFields.sdoHighVoltage;
    end
  end

  // Pump and guard drive, one cycle after the comparator
  always_ff @(posedge clk) begin
    if (rst) begin
      pumpUp          <= 1'b0;
      pumpDown        <= 1'b0;
      cycleSlipInject <= 1'b0;
    end else begin
      pumpUp          <= next_pumpUp;
      pumpDown        <= next_pumpDown;
      cycleSlipInject <= next_slipInject;
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence seqPdWrite;
    wrStrobe && selPd;
  endsequence

  sequence seqExactWrite;
    wrStrobe && selExact;
  endsequence

  // Last data bit of a write frame
  sequence seqLastWriteBit;
    spiEnable && sckRise && spiState == ppe_pkg::SP_WRITE && bitCount == ppe_pkg::FRAME_LAST;
  endsequence

  // Serial clock fall inside a read data phase
  sequence seqReadFall;
    spiEnable && sckFall && spiState == ppe_pkg::SP_READ;
  endsequence

  pd_defaults_a: assert property ($past(rst) && !rst |-> pdCtrl == ppe_pkg::PD_RESET)
    else $error("phase detector control not at defaults after reset");
  exact_reset_a: assert property ($past(rst) && !rst |-> exactChannelCount == 14'h0000
    && exactWord == ppe_pkg::EXACT_RESET) else $error("exact register not cleared by reset");
  up_gate_a: assert property (!pdFields.detectorUpEnable && !pdFields.forcePumpUp
    |=> !pumpUp) else $error("pump up active while disabled");
  down_gate_a: assert property (!pdFields.detectorDownEnable && !pdFields.forcePumpDown
    |=> !pumpDown) else $error("pump down active while disabled");
  force_up_a: assert property (pdFields.forcePumpUp |=> pumpUp)
    else $error("forced pump up not on");
  force_down_a: assert property (pdFields.forcePumpDown |=> pumpDown)
    else $error("forced pump down not on");
  guard_off_a: assert property (guardMode == ppe_pkg::GUARD_OFF |=> !cycleSlipInject)
    else $error("slip guard injects while off");
  guard_level1_a: assert property (guardMode == ppe_pkg::GUARD_LVL1
    && phaseErrorPs > ppe_pkg::GUARD_THR1_PS |=> cycleSlipInject)
    else $error("slip guard missed 5.4 ns");
  sdo_level_a: assert property (seqPdWrite |=> ##1 sdoHighVoltage == $past(wrWord[22], 2))
    else $error("drive level not taken from bit 22");
  reserved_keep_a: assert property (seqPdWrite |=> pdWord == $past(wrWord))
    else $error("phase detector word not stored whole");
  exact_off_a: assert property (exactWord[13:0] < ppe_pkg::EXACT_MIN_COUNT
    |=> !exactEnable && !correctionPulse) else $error("exact mode on with count below two");

  // Slip guard: each level fires past its window and stays quiet inside it
  guard_level2_a: assert property (guardMode == ppe_pkg::GUARD_LVL2
    && phaseErrorPs > ppe_pkg::GUARD_THR2_PS |=> cycleSlipInject)
    else $error("slip guard missed 14.4 ns");
  guard_level3_a: assert property (guardMode == ppe_pkg::GUARD_LVL3
    && phaseErrorPs > ppe_pkg::GUARD_THR3_PS |=> cycleSlipInject)
    else $error("slip guard missed 24.1 ns");
  guard_below1_a: assert property (guardMode == ppe_pkg::GUARD_LVL1
    && phaseErrorPs <= ppe_pkg::GUARD_THR1_PS |=> !cycleSlipInject)
    else $error("slip guard fired inside 5.4 ns");
  guard_below2_a: assert property (guardMode == ppe_pkg::GUARD_LVL2
    && phaseErrorPs <= ppe_pkg::GUARD_THR2_PS |=> !cycleSlipInject)
    else $error("slip guard fired inside 14.4 ns");
  guard_below3_a: assert property (guardMode == ppe_pkg::GUARD_LVL3
    && phaseErrorPs <= ppe_pkg::GUARD_THR3_PS |=> !cycleSlipInject)
    else $error("slip guard fired inside 24.1 ns");

  // Enabled detector levels reach the pumps one cycle later
  up_follow_a: assert property (detUpRaw && pdFields.detectorUpEnable |=> pumpUp)
    else $error("pump up did not follow detector");
  down_follow_a: assert property (detDownRaw && pdFields.detectorDownEnable |=> pumpDown)
    else $error("pump down did not follow detector");

  // Exact mode on for counts of two and above; exact word stored whole, phase detector word copied whole
  exact_on_a: assert property (exactWord[13:0] >= ppe_pkg::EXACT_MIN_COUNT
    |=> exactEnable) else $error("exact mode off with a valid count");
  exact_store_a: assert property (seqExactWrite |=> exactWord == $past(wrWord))
    else $error("exact word not stored whole");
  pd_copy_a: assert property (1'b1 |=> pdCtrl == $past(pdFields))
    else $error("phase detector copy lags or differs");

  // Serial port: a full write commits, a read phase drives the pin
  write_commit_a: assert property (seqLastWriteBit |=> wrStrobe)
    else $error("full write frame not committed");
  read_drive_a: assert property (seqReadFall |=> !sdoOe_n)
    else $error("read data pin not driven");

endmodule // ppe_top
`default_nettype wire
